// >>> hdl/gsip_params.svh
// Constants for the gauge serial input port
`ifndef GSIP_PARAMS_SVH
`define GSIP_PARAMS_SVH
`define GSIP_WORD_BITS 12
`define GSIP_SEL_MSB 11
`define GSIP_SEL_LSB 10
`define GSIP_MAJOR_BITS 10
`define GSIP_MINOR_BITS 8
`define GSIP_SEL_MAJOR 2'h0
`define GSIP_SEL_MINOR1 2'h1
`define GSIP_SEL_MINOR2 2'h2
`define GSIP_SEL_OFF 2'h3
`define GSIP_SHIFT_RESET 12'h000
`define GSIP_MAJOR_RESET 10'h000
`define GSIP_MINOR_RESET 8'h00
`define GSIP_PIN_COUNT 5
`define GSIP_PIN_SCLK 0
`define GSIP_PIN_SEL 1
`define GSIP_PIN_DIN 2
`define GSIP_PIN_SHORT 3
`define GSIP_PIN_HOT 4
`endif

// >>> hdl/gsip_pkg.sv
// Types for the gauge serial input port
`include "gsip_params.svh"
package gsip_pkg;
   typedef logic [`GSIP_WORD_BITS-1:0] gsip_word_t;
   typedef logic [1:0] gsip_sel_t;
endpackage

// >>> hdl/gsip_sync.sv
// Two-flop synchroniser with edge detection for the port pins
`timescale 1ns/1ps
`default_nettype none
module gsip_sync (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic pinIn,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic last_reg, last_next;

   // First stage feeds only the second
   always_comb begin
      meta_next = pinIn;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   // Edges judged only on settled samples
   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule // gsip_sync
`default_nettype wire

// >>> hdl/gsip_port.sv
// Gauge serial input port: shift register, word latch, fault re-arm
`timescale 1ns/1ps
`default_nettype none
`include "gsip_params.svh"
// Summary of operation
// [RULE1] Rising shift clock samples serial input
// [RULE2] Serial output changes on falling edge
// [RULE3] Shift only while load-select is high
// [RULE4] Load-select fall latches word to gauge
// [RULE5] Load-select fall re-enables faulted drivers
// [RULE6] Reset clears all registers and latches
// [RULE7] Fault output low on short or overheat
// [RULE8] Twelve-bit register; old bits shift out
// [RULE9] Host may chain devices through serial output
// [RULE10] Top two bits select target gauge
// [RULE11] Select 11 disables all coil outputs
// [RULE12] Major ten-bit code, minors eight-bit
// [RULE13] Words arrive most significant bit first
// [RULE14] Low load-select holds word and register
module gsip_port
   import gsip_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic shiftClk,
   input wire logic loadSel,
   input wire logic serIn,
   input wire logic shortDet,
   input wire logic overTemp,
   output logic serOut,
   output logic faultOut_b,
   output logic [`GSIP_MAJOR_BITS-1:0] majorCode,
   output logic [`GSIP_MINOR_BITS-1:0] minor1Code,
   output logic [`GSIP_MINOR_BITS-1:0] minor2Code,
   output logic coilEnable,
   output logic majorUpdate,
   output logic minor1Update,
   output logic minor2Update
);
   // Pins gathered so that one bank of synchronisers serves them all
   logic [`GSIP_PIN_COUNT-1:0] pinRaw;
   logic [`GSIP_PIN_COUNT-1:0] pinLvl;
   logic [`GSIP_PIN_COUNT-1:0] pinRise;
   logic [`GSIP_PIN_COUNT-1:0] pinFall;
   logic sclkRise, sclkFall;
   logic selLvl, selFall;
   logic dinLvl;
   logic faultLvl;

   assign pinRaw[`GSIP_PIN_SCLK] = shiftClk;
   assign pinRaw[`GSIP_PIN_SEL] = loadSel;
   assign pinRaw[`GSIP_PIN_DIN] = serIn;
   assign pinRaw[`GSIP_PIN_SHORT] = shortDet;
   assign pinRaw[`GSIP_PIN_HOT] = overTemp;

   // Every pin passes two flops before any logic reads it
   genvar pinIdx;
   generate
      for (pinIdx = 0; pinIdx < `GSIP_PIN_COUNT; pinIdx++) begin : gPinSync
         gsip_sync uSync (
            .mclk(mclk),
            .rst_b(rst_b),
            .pinIn(pinRaw[pinIdx]),
            .level(pinLvl[pinIdx]),
            .rise(pinRise[pinIdx]),
            .fall(pinFall[pinIdx])
         );
      end
   endgenerate

   // Only the edges each path needs are picked out; the rest stay unread
   assign sclkRise = pinRise[`GSIP_PIN_SCLK];
   assign sclkFall = pinFall[`GSIP_PIN_SCLK];
   assign selLvl = pinLvl[`GSIP_PIN_SEL];
   assign selFall = pinFall[`GSIP_PIN_SEL];
   assign dinLvl = pinLvl[`GSIP_PIN_DIN];
   // Short and overheat trip the drivers alike
   assign faultLvl = pinLvl[`GSIP_PIN_SHORT] | pinLvl[`GSIP_PIN_HOT];

   gsip_word_t shift_reg, shift_next;
   logic serOut_reg, serOut_next;
   gsip_sel_t sel;

   // Shift path: the register and the serial output behind it
   // A frame shorter than twelve bits leaves old bits mixed in
   always_comb begin
      shift_next = shift_reg;
      serOut_next = serOut_reg;
      // Edges while deselected are dropped, contents kept
      if (selLvl && sclkRise) begin // [RULE3] [RULE14]
         shift_next = {shift_reg[`GSIP_WORD_BITS-2:0], dinLvl}; // [RULE1] [RULE13] [RULE8]
      end
      // Output lags to the fall so a chained device samples settled data
      if (selLvl && sclkFall) begin // [RULE2] [RULE9]
         serOut_next = shift_reg[`GSIP_WORD_BITS-1]; // [RULE8]
      end
   end

   // Synchronous reset stands in for the power-on clear
   always_ff @(posedge mclk) begin
      if (!rst_b) begin // [RULE6]
         shift_reg <= `GSIP_SHIFT_RESET;
         serOut_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         serOut_reg <= serOut_next;
      end
   end

   assign sel = shift_reg[`GSIP_SEL_MSB:`GSIP_SEL_LSB]; // [RULE10]

   logic [`GSIP_MAJOR_BITS-1:0] major_reg, major_next;
   logic [`GSIP_MINOR_BITS-1:0] minor1_reg, minor1_next;
   logic [`GSIP_MINOR_BITS-1:0] minor2_reg, minor2_next;
   logic enable_reg, enable_next;
   logic majUpd_reg, majUpd_next;
   logic m1Upd_reg, m1Upd_next;
   logic m2Upd_reg, m2Upd_next;

   // Word latch: the load-select fall hands the word to the addressed gauge
   always_comb begin
      major_next = major_reg;
      minor1_next = minor1_reg;
      minor2_next = minor2_reg;
      enable_next = enable_reg;
      majUpd_next = 1'b0;
      m1Upd_next = 1'b0;
      m2Upd_next = 1'b0;
      if (selFall) begin // [RULE4]
         case (sel)
            `GSIP_SEL_MAJOR: begin
               major_next = shift_reg[`GSIP_MAJOR_BITS-1:0]; // [RULE12]
               enable_next = 1'b1;
               majUpd_next = 1'b1;
            end
            `GSIP_SEL_MINOR1: begin
               minor1_next = shift_reg[`GSIP_MINOR_BITS-1:0]; // [RULE12]
               enable_next = 1'b1;
               m1Upd_next = 1'b1;
            end
            `GSIP_SEL_MINOR2: begin
               minor2_next = shift_reg[`GSIP_MINOR_BITS-1:0]; // [RULE12]
               enable_next = 1'b1;
               m2Upd_next = 1'b1;
            end
            // Codes are kept so the next load picks up where it left off
            `GSIP_SEL_OFF: begin
               enable_next = 1'b0; // [RULE11]
            end
            default: begin
               enable_next = 1'b0;
            end
         endcase
      end
   end

   // Codes, enable and update pulses registered together
   always_ff @(posedge mclk) begin
      if (!rst_b) begin // [RULE6]
         major_reg <= `GSIP_MAJOR_RESET;
         minor1_reg <= `GSIP_MINOR_RESET;
         minor2_reg <= `GSIP_MINOR_RESET;
         enable_reg <= 1'b0;
         majUpd_reg <= 1'b0;
         m1Upd_reg <= 1'b0;
         m2Upd_reg <= 1'b0;
      end else begin
         major_reg <= major_next;
         minor1_reg <= minor1_next;
         minor2_reg <= minor2_next;
         enable_reg <= enable_next;
         majUpd_reg <= majUpd_next;
         m1Upd_reg <= m1Upd_next;
         m2Upd_reg <= m2Upd_next;
      end
   end

   logic tripped_reg, tripped_next;
   logic fault_reg, fault_next;
   logic coilEn_reg, coilEn_next;

   // Protection: a trip holds until a load arrives with the fault gone
   always_comb begin
      tripped_next = tripped_reg;
      // Fault still present wins over re-arm
      if (faultLvl) begin
         tripped_next = 1'b1;
      end else if (selFall) begin
         tripped_next = 1'b0; // [RULE5]
      end
      fault_next = ~faultLvl; // [RULE7]
      // Enable registered with the trip so drivers never see a glitch
      coilEn_next = enable_next & ~tripped_next;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin // [RULE6]
         tripped_reg <= 1'b0;
         fault_reg <= 1'b1;
         coilEn_reg <= 1'b0;
      end else begin
         tripped_reg <= tripped_next;
         fault_reg <= fault_next;
         coilEn_reg <= coilEn_next;
      end
   end

   // Every output comes straight from a flop
   assign serOut = serOut_reg;
   assign faultOut_b = fault_reg;
   assign majorCode = major_reg;
   assign minor1Code = minor1_reg;
   assign minor2Code = minor2_reg;
   assign coilEnable = coilEn_reg;
   assign majorUpdate = majUpd_reg;
   assign minor1Update = m1Upd_reg;
   assign minor2Update = m2Upd_reg;
endmodule // gsip_port
`default_nettype wire

// >>> testbench/gsip_port_chk.sv
// Port assertions for the gauge serial input port
`timescale 1ns/1ps
`default_nettype none
`include "gsip_params.svh"
module gsip_port_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic loadSel,
   input wire logic shortDet,
   input wire logic overTemp,
   input wire logic serOut,
   input wire logic faultOut_b,
   input wire logic [`GSIP_MAJOR_BITS-1:0] majorCode,
   input wire logic coilEnable,
   input wire logic majorUpdate,
   input wire logic minor1Update,
   input wire logic minor2Update
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Six samples cover the synchroniser lag
   a_reset_clear: assert property ($rose(rst_b) |-> !majorCode && !coilEnable && faultOut_b)
      else $error("outputs not cleared");
   a_fault_low: assert property ((shortDet || overTemp)[*6] |-> !faultOut_b)
      else $error("fault not flagged");
   a_trip_off: assert property ((shortDet || overTemp)[*6] |-> !coilEnable)
      else $error("drivers on in fault");
   a_pulse_single: assert property (majorUpdate |=> !majorUpdate)
      else $error("update pulse too long");
   a_update_onehot: assert property ($onehot0({majorUpdate, minor1Update, minor2Update}))
      else $error("two gauges updated");
   a_code_hold: assert property ($changed(majorCode) |-> majorUpdate)
      else $error("code moved without load");
   a_enable_load: assert property ($rose(coilEnable) |-> majorUpdate || minor1Update || minor2Update)
      else $error("enable without load");
   a_serout_idle: assert property (!loadSel[*8] |-> $stable(serOut))
      else $error("serial out moved while idle");
endmodule // gsip_port_chk
bind gsip_port gsip_port_chk chk (.mclk, .rst_b, .loadSel, .shortDet, .overTemp, .serOut,
   .faultOut_b, .majorCode, .coilEnable, .majorUpdate, .minor1Update, .minor2Update);
`default_nettype wire

// >>> testbench/gsip_host.sv
// Host model driving link clock, load-select and serial data
`timescale 1ns/1ps
`default_nettype none
module gsip_host (
   input wire logic mclk,
   input wire logic serOut,
   output logic shiftClk,
   output logic loadSel,
   output logic serIn
);
   // Clock parks low between frames
   initial {shiftClk, loadSel, serIn} = 3'h0;
   // Eight mclk a half period gives 64 ns; old collects a bit before each rise
   task automatic send(input logic [11:0] w, output logic [11:0] old, input logic sel);
      loadSel = sel;
      for (int i = 11; i >= 0; i--) begin
         serIn = w[i];
         repeat (8) @(posedge mclk);
         // Sampled just before the rise, as a chained device would
         #1 old = {old[10:0], serOut};
         shiftClk = 1'b1;
         repeat (8) @(posedge mclk);
         #1 shiftClk = 1'b0;
      end
      // Select held past the last fall; twelve samples make the old word
      repeat (8) @(posedge mclk);
      #1 loadSel = 1'b0;
      serIn = ~serIn; // Released line shows no stale bit
      repeat (8) @(posedge mclk);
      #1;
   endtask
endmodule // gsip_host
`default_nettype wire

// >>> testbench/test_gauge_serial_input_port.sv
// Self-checking bench for the gauge serial input port
`timescale 1ns/1ps
`default_nettype none
`include "gsip_params.svh"
module test_gauge_serial_input_port;
   import gsip_pkg::*;
   logic mclk, rst_b, shiftClk, loadSel, serIn, shortDet, overTemp, serOut, faultOut_b;
   logic coilEnable, majorUpdate, minor1Update, minor2Update, eEn, tripped;
   logic [`GSIP_MAJOR_BITS-1:0] majorCode, eMaj;
   logic [`GSIP_MINOR_BITS-1:0] minor1Code, minor2Code, eM1, eM2;
   logic [2:0] seen;
   logic [31:0] lfsrState = 32'hc726;
   gsip_word_t w, prevWord, oldOut;
   int mismatches = 0, cmp_count = 0;
   gsip_port dut (.mclk, .rst_b, .shiftClk, .loadSel, .serIn, .shortDet, .overTemp, .serOut,
      .faultOut_b, .majorCode, .minor1Code, .minor2Code, .coilEnable, .majorUpdate,
      .minor1Update, .minor2Update);
   gsip_host host (.mclk, .serOut, .shiftClk, .loadSel, .serIn);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Pulses last one cycle, so gather them
   always @(posedge mclk) seen <= seen | {minor2Update, minor1Update, majorUpdate};
   function gsip_word_t lfsr_next();
      lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
      return lfsrState[11:0];
   endfunction
   function logic [2:0] exp_pulse(input gsip_word_t v);
      return (v[11:10] == `GSIP_SEL_OFF) ? 3'h0 : 3'h1 << v[11:10];
   endfunction
   // One compare task per kind of result
   task automatic chk_codes(input logic [25:0] got, input logic [25:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: codes %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input gsip_word_t got, input gsip_word_t exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: word out %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pulse(input logic [2:0] got, input logic [2:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: pulses %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_drive(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: enable and fault %h expected %h", $time, got, exp);
      end
   endtask
   // One frame, then codes, pulses, enable and the word shifted out
   task automatic load(input gsip_word_t v);
      seen = 3'h0;
      host.send(v, oldOut, 1'b1);
      if (!(shortDet | overTemp)) tripped = 1'b0;
      eEn = (v[11:10] != `GSIP_SEL_OFF);
      case (v[11:10])
         `GSIP_SEL_MAJOR: eMaj = v[9:0];
         `GSIP_SEL_MINOR1: eM1 = v[7:0];
         `GSIP_SEL_MINOR2: eM2 = v[7:0];
         default: ;
      endcase
      chk_codes({majorCode, minor1Code, minor2Code}, {eMaj, eM1, eM2});
      chk_word(oldOut, prevWord);
      chk_pulse(seen, exp_pulse(v));
      chk_drive({coilEnable, faultOut_b}, {eEn && !tripped, !(shortDet | overTemp)});
      prevWord = v;
   endtask
   initial begin
      {rst_b, shortDet, overTemp, tripped, eMaj, eM1, eM2, prevWord} = '0;
      repeat (16) @(posedge mclk);
      #1 rst_b = 1'b1;
      // Every select with both extreme codes, then random words
      for (int i = 0; i < 24; i++) begin
         w = lfsr_next();
         w[11:10] = i[1:0];
         if (i < 8) w[9:0] = {10{i[2]}};
         load(w);
      end
      // Frame with load-select low leaves register, output and codes alone
      host.send(12'h5a5, oldOut, 1'b0);
      chk_word(oldOut, {12{prevWord[11]}});
      chk_codes({majorCode, minor1Code, minor2Code}, {eMaj, eM1, eM2});
      load(lfsr_next());
      for (int f = 1; f < 3; f++) begin
         {overTemp, shortDet} = f[1:0];
         tripped = 1'b1;
         repeat (8) @(posedge mclk);
         #1 chk_drive({coilEnable, faultOut_b}, 2'h0);
         load(12'h155);
         {overTemp, shortDet} = 2'h0;
         repeat (8) @(posedge mclk);
         // Fault gone, yet drivers stay off until the next load
         #1 chk_drive({coilEnable, faultOut_b}, 2'h1);
         load(12'h6aa);
      end
      rst_b = 1'b0;
      repeat (4) @(posedge mclk);
      #1 rst_b = 1'b1;
      {eMaj, eM1, eM2, prevWord, tripped} = '0;
      chk_codes({majorCode, minor1Code, minor2Code}, 26'h0);
      chk_drive({coilEnable, faultOut_b}, 2'h1);
      load(12'hb3c);
      print_verdict();
   end
   // Hang guard well beyond the run
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
endmodule // test_gauge_serial_input_port
`default_nettype wire
